// file: hw/ppo_top.sv
// pulse pattern output registers with an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module ppo_top #(
    parameter int ADDR_W = ppo_pkg::ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] cmp_match,
    output logic [15:0] pulse_out
);
    logic aw_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic w_held_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] en_high_reg;
    logic [7:0] en_low_reg;
    logic [7:0] trig_sel_reg;
    logic [7:0] next_high_reg;
    logic [7:0] next_low_reg;
    logic [3:0] cmp_q_reg;
    logic [3:0] trig;
    logic wr_fire;
    logic wr_en;
    logic shared_high;
    logic shared_low;
    logic [7:0] read_value;

    ppo_byte_if hi_if();
    ppo_byte_if lo_if();

    // known register offsets; anything else answers with an error
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = (a == ppo_pkg::OFS_TRIG_SEL) || (a == ppo_pkg::OFS_EN_HIGH) || (a == ppo_pkg::OFS_EN_LOW)
            || (a == ppo_pkg::OFS_LEVEL_HIGH) || (a == ppo_pkg::OFS_LEVEL_LOW) || (a == ppo_pkg::OFS_NEXT_HIGH)
            || (a == ppo_pkg::OFS_NEXT_LOW) || (a == ppo_pkg::OFS_NEXT_HIGH_ALT)
            || (a == ppo_pkg::OFS_NEXT_LOW_ALT);
    endfunction

    // next pattern view; in split mode the idle nibble reads ones
    function automatic logic [7:0] next_view(input logic [7:0] v, input logic shared, input logic alt);
        if (shared) begin
            next_view = alt ? 8'hFF : v;
        end else if (alt) begin
            next_view = {4'hF, v[3:0]};
        end else begin
            next_view = {v[7:4], 4'hF};
        end
    endfunction

    // next pattern write; the idle nibble keeps its value
    function automatic logic [7:0] next_merge(input logic [7:0] old, input logic [7:0] wd, input logic shared,
        input logic alt);
        if (shared) begin
            next_merge = alt ? old : wd;
        end else if (alt) begin
            next_merge = {old[7:4], wd[3:0]};
        end else begin
            next_merge = {wd[7:4], old[3:0]};
        end
    endfunction

    // a byte is shared when both its groups pick the same channel
    assign shared_high = trig_sel_reg[ppo_pkg::SEL_G3_LSB +: 2] == trig_sel_reg[ppo_pkg::SEL_G2_LSB +: 2];
    assign shared_low = trig_sel_reg[ppo_pkg::SEL_G1_LSB +: 2] == trig_sel_reg[ppo_pkg::SEL_G0_LSB +: 2];

    // write address and data are caught independently, in either order
    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_en = wr_fire && wstrb0_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg <= wdata[7:0];
            wstrb0_reg <= wstrb[0];
        end
    end

    // write response, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= ppo_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_known(awaddr_reg) ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // control registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_high_reg <= ppo_pkg::EN_RST;
            en_low_reg <= ppo_pkg::EN_RST;
            trig_sel_reg <= ppo_pkg::TRIG_SEL_RST;
        end else if (wr_en) begin
            if (awaddr_reg == ppo_pkg::OFS_EN_HIGH) begin
                en_high_reg <= wdata_reg;
            end else if (awaddr_reg == ppo_pkg::OFS_EN_LOW) begin
                en_low_reg <= wdata_reg;
            end else if (awaddr_reg == ppo_pkg::OFS_TRIG_SEL) begin
                trig_sel_reg <= wdata_reg;
            end
        end
    end

    // next pattern registers; trigger samples them before this edge's write lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_high_reg <= ppo_pkg::NEXT_RST;
            next_low_reg <= ppo_pkg::NEXT_RST;
        end else if (wr_en) begin
            if (awaddr_reg == ppo_pkg::OFS_NEXT_HIGH) begin
                next_high_reg <= next_merge(next_high_reg, wdata_reg, shared_high, 1'b0);
            end else if (awaddr_reg == ppo_pkg::OFS_NEXT_HIGH_ALT) begin
                next_high_reg <= next_merge(next_high_reg, wdata_reg, shared_high, 1'b1);
            end else if (awaddr_reg == ppo_pkg::OFS_NEXT_LOW) begin
                next_low_reg <= next_merge(next_low_reg, wdata_reg, shared_low, 1'b0);
            end else if (awaddr_reg == ppo_pkg::OFS_NEXT_LOW_ALT) begin
                next_low_reg <= next_merge(next_low_reg, wdata_reg, shared_low, 1'b1);
            end
        end
    end

    // a held compare match must not transfer again, so take its rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_q_reg <= 4'h0;
        end else begin
            cmp_q_reg <= cmp_match;
        end
    end

    assign trig = cmp_match & ~cmp_q_reg;

    // hand each byte its enables, pattern, triggers and software write
    assign hi_if.en = en_high_reg;
    assign hi_if.nxt = next_high_reg;
    assign hi_if.sel_hi = trig_sel_reg[ppo_pkg::SEL_G3_LSB +: 2];
    assign hi_if.sel_lo = trig_sel_reg[ppo_pkg::SEL_G2_LSB +: 2];
    assign hi_if.trig = trig;
    assign hi_if.wr = wr_en && (awaddr_reg == ppo_pkg::OFS_LEVEL_HIGH);
    assign hi_if.wdata = wdata_reg;
    assign lo_if.en = en_low_reg;
    assign lo_if.nxt = next_low_reg;
    assign lo_if.sel_hi = trig_sel_reg[ppo_pkg::SEL_G1_LSB +: 2];
    assign lo_if.sel_lo = trig_sel_reg[ppo_pkg::SEL_G0_LSB +: 2];
    assign lo_if.trig = trig;
    assign lo_if.wr = wr_en && (awaddr_reg == ppo_pkg::OFS_LEVEL_LOW);
    assign lo_if.wdata = wdata_reg;

    ppo_level_unit u_level_high (
        .aclk(aclk),
        .aresetn(aresetn),
        .bi(hi_if.unit)
    );

    ppo_level_unit u_level_low (
        .aclk(aclk),
        .aresetn(aresetn),
        .bi(lo_if.unit)
    );

    assign pulse_out = {hi_if.level, lo_if.level};

    // read decode
    always_comb begin
        if (araddr == ppo_pkg::OFS_TRIG_SEL) begin
            read_value = trig_sel_reg;
        end else if (araddr == ppo_pkg::OFS_EN_HIGH) begin
            read_value = en_high_reg;
        end else if (araddr == ppo_pkg::OFS_EN_LOW) begin
            read_value = en_low_reg;
        end else if (araddr == ppo_pkg::OFS_LEVEL_HIGH) begin
            read_value = hi_if.level;
        end else if (araddr == ppo_pkg::OFS_LEVEL_LOW) begin
            read_value = lo_if.level;
        end else if (araddr == ppo_pkg::OFS_NEXT_HIGH) begin
            read_value = next_view(next_high_reg, shared_high, 1'b0);
        end else if (araddr == ppo_pkg::OFS_NEXT_HIGH_ALT) begin
            read_value = next_view(next_high_reg, shared_high, 1'b1);
        end else if (araddr == ppo_pkg::OFS_NEXT_LOW) begin
            read_value = next_view(next_low_reg, shared_low, 1'b0);
        end else if (araddr == ppo_pkg::OFS_NEXT_LOW_ALT) begin
            read_value = next_view(next_low_reg, shared_low, 1'b1);
        end else begin
            read_value = 8'h00;
        end
    end

    // one read outstanding; address refused while data waits
    assign arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= ppo_pkg::RESP_OKAY;
        end else if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, read_value};
            rresp_reg <= addr_known(araddr) ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    property p_reset_clear;
        @(posedge aclk)
        !aresetn |=> en_high_reg == 8'h00 && en_low_reg == 8'h00 && pulse_out == 16'h0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("enable or level not cleared by reset");
    property p_enable_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && awaddr_reg == ppo_pkg::OFS_EN_LOW |=> en_low_reg == $past(wdata_reg);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable low write not stored");
    property p_shared_next;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && awaddr_reg == ppo_pkg::OFS_NEXT_HIGH && shared_high |=> next_high_reg == $past(wdata_reg);
    endproperty
    a_shared_next: assert property (p_shared_next) else $error("shared next write not whole byte");
    property p_split_read;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == ppo_pkg::OFS_NEXT_LOW && !shared_low
            |=> rvalid && rdata[3:0] == 4'hF && rdata[7:4] == $past(next_low_reg[7:4]);
    endproperty
    a_split_read: assert property (p_split_read) else $error("split next read wrong");
    property p_single_trig;
        @(posedge aclk) disable iff (!aresetn)
        cmp_match != 4'h0 ##1 cmp_match == $past(cmp_match) |-> trig == 4'h0;
    endproperty
    a_single_trig: assert property (p_single_trig) else $error("held compare match retriggered");
    property p_chan_sel;
        @(posedge aclk) disable iff (!aresetn)
        trig[0] && !trig[3] && trig_sel_reg[ppo_pkg::SEL_G0_LSB +: 2] == 2'h3 && !lo_if.wr
            |=> pulse_out[3:0] == $past(pulse_out[3:0]);
    endproperty
    a_chan_sel: assert property (p_chan_sel) else $error("group moved on unselected channel");
    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> bvalid ##0 (bresp == ppo_pkg::RESP_OKAY || bresp == ppo_pkg::RESP_SLVERR);
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write not answered next cycle");
    c_shared_write: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_en && awaddr_reg == ppo_pkg::OFS_NEXT_HIGH && shared_high);
    c_split_read: cover property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == ppo_pkg::OFS_NEXT_LOW_ALT && !shared_low);
    c_trigger: cover property (@(posedge aclk) disable iff (!aresetn) trig != 4'h0 && en_high_reg != 8'h00);
endmodule

// file: hw/ppo_pkg.sv
// constants shared by the pulse pattern output block
package ppo_pkg;
    localparam int ADDR_W = 6;
    // register byte offsets
    localparam logic [5:0] OFS_TRIG_SEL = 6'h00;
    localparam logic [5:0] OFS_EN_HIGH = 6'h04;
    localparam logic [5:0] OFS_EN_LOW = 6'h08;
    localparam logic [5:0] OFS_LEVEL_HIGH = 6'h0C;
    localparam logic [5:0] OFS_LEVEL_LOW = 6'h10;
    localparam logic [5:0] OFS_NEXT_HIGH = 6'h14;
    localparam logic [5:0] OFS_NEXT_LOW = 6'h18;
    localparam logic [5:0] OFS_NEXT_HIGH_ALT = 6'h1C;
    localparam logic [5:0] OFS_NEXT_LOW_ALT = 6'h20;
    // values after reset
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] NEXT_RST = 8'h00;
    localparam logic [7:0] TRIG_SEL_RST = 8'hFF;
    // trigger select field positions, two bits per group
    localparam int SEL_G3_LSB = 6;
    localparam int SEL_G2_LSB = 4;
    localparam int SEL_G1_LSB = 2;
    localparam int SEL_G0_LSB = 0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/ppo_byte_if.sv
// signals between the register file and one byte of output level logic
`timescale 1ns/100ps
interface ppo_byte_if;
    logic [7:0] en;
    logic [7:0] nxt;
    logic [1:0] sel_hi;
    logic [1:0] sel_lo;
    logic [3:0] trig;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] level;
    modport ctl (output en, output nxt, output sel_hi, output sel_lo, output trig, output wr, output wdata,
        input level);
    modport unit (input en, input nxt, input sel_hi, input sel_lo, input trig, input wr, input wdata,
        output level);
endinterface

// file: hw/ppo_level_unit.sv
// one byte of output level: trigger transfer and protected software write
`timescale 1ns/100ps
module ppo_level_unit (
    input wire logic aclk,
    input wire logic aresetn,
    ppo_byte_if.unit bi
);
    logic [7:0] level_reg;
    logic [7:0] level_next;
    logic trig_hi;
    logic trig_lo;
    logic [7:0] xfer_mask;
    logic [7:0] wr_mask;

    // each nibble follows the compare match its select code names
    assign trig_hi = bi.trig[bi.sel_hi];
    assign trig_lo = bi.trig[bi.sel_lo];
    // only enabled bits move on a trigger
    assign xfer_mask = bi.en & {{4{trig_hi}}, {4{trig_lo}}};
    // software reaches only the disabled bits
    assign wr_mask = bi.wr ? ~bi.en : 8'h00;

    // masks never overlap, so the merge needs no priority
    always_comb begin
        level_next = (level_reg & ~xfer_mask & ~wr_mask) | (bi.nxt & xfer_mask) | (bi.wdata & wr_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_reg <= ppo_pkg::LEVEL_RST;
        end else begin
            level_reg <= level_next;
        end
    end

    assign bi.level = level_reg;

    property p_xfer;
        @(posedge aclk) disable iff (!aresetn)
        xfer_mask != 8'h00 |=> (level_reg & $past(xfer_mask)) == ($past(bi.nxt) & $past(xfer_mask));
    endproperty
    a_xfer: assert property (p_xfer) else $error("enabled bit missed its transfer");
    property p_no_xfer;
        @(posedge aclk) disable iff (!aresetn)
        !bi.wr |=> ((level_reg ^ $past(level_reg)) & ~$past(bi.en)) == 8'h00;
    endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("disabled bit changed on trigger");
    property p_protect;
        @(posedge aclk) disable iff (!aresetn)
        bi.wr |=> ((level_reg ^ $past(level_reg)) & $past(bi.en) & ~$past(xfer_mask)) == 8'h00;
    endproperty
    a_protect: assert property (p_protect) else $error("protected level bit was written");
    property p_init_write;
        @(posedge aclk) disable iff (!aresetn)
        bi.wr |=> (level_reg & ~$past(bi.en)) == ($past(bi.wdata) & ~$past(bi.en));
    endproperty
    a_init_write: assert property (p_init_write) else $error("initial level write lost");
    c_xfer: cover property (@(posedge aclk) disable iff (!aresetn) xfer_mask != 8'h00 && bi.wr);
endmodule

// file: hw/ppo_top_fix_note_unused.sv
// no logic here; the block lives in ppo_top and ppo_level_unit

// file: test/ppo_timer_model.sv
// model of the timer compare-match source and the port output pins
`timescale 1ns/100ps
module ppo_timer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] fire,
    input wire logic [3:0] hold,
    input wire logic [15:0] dir,
    input wire logic [15:0] pulse_out,
    output logic [3:0] cmp_match,
    output logic [15:0] pins
);
    // fire gives a one-cycle match; hold keeps the match high to probe edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_match <= 4'h0;
        end else begin
            cmp_match <= fire | hold;
        end
    end
    // a pin shows the pulse level only while its direction bit is set
    assign pins = pulse_out & dir;
endmodule

// file: test/tb_top.sv
// self-checking bench for the pulse pattern output registers
`timescale 1ns/100ps
module tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, cmp_match, fire, hold;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] pulse_out, pins, dir, lev, en, nx;
    logic [5:0] ofs [9];
    logic [7:0] rst_v [9];
    int n_mismatch, num_checks, i, k;

    ppo_top #(.ADDR_W(6)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmp_match(cmp_match),
        .pulse_out(pulse_out));
    ppo_timer_model timer (.aclk(aclk), .aresetn(aresetn), .fire(fire), .hold(hold), .dir(dir),
        .pulse_out(pulse_out), .cmp_match(cmp_match), .pins(pins));

    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // address and data offered together, each dropped once taken; response kept in rs
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // read one register; data in rd, response in rs; rready stays high between reads
    task automatic rd_reg(input logic [5:0] a);
        logic ar_done;
        ar_done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ar_done && arready) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        rd_reg(a);
        check(rd, {24'h000000, e});
    endtask

    // one-cycle compare match on channel c, then let the level settle
    task automatic fire_ch(input int c);
        fire <= 4'(4'h1 << c);
        @(posedge aclk);
        fire <= 4'h0;
        cyc(3);
    endtask

    // expected levels after a trigger that hits the groups in mask m
    function automatic logic [15:0] xfer(input logic [15:0] m);
        return (lev & ~(en & m)) | (nx & en & m);
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the whole run takes well under 3000 cycles
    initial begin
        cyc(20000);
        $display("watchdog expired at %0t", $time);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        fire = 4'h0;
        hold = 4'h0;
        dir = 16'hFF00;
        ofs = '{ppo_pkg::OFS_TRIG_SEL, ppo_pkg::OFS_EN_HIGH, ppo_pkg::OFS_EN_LOW, ppo_pkg::OFS_LEVEL_HIGH,
            ppo_pkg::OFS_LEVEL_LOW, ppo_pkg::OFS_NEXT_HIGH, ppo_pkg::OFS_NEXT_LOW, ppo_pkg::OFS_NEXT_HIGH_ALT,
            ppo_pkg::OFS_NEXT_LOW_ALT};
        rst_v = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
        cyc(20);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, shared trigger after reset so alternate addresses read ones
        for (i = 0; i < 9; i++) begin
            rchk(ofs[i], rst_v[i]);
        end
        check({16'h0000, pulse_out}, 32'h00000000);
        rchk(6'h24, 8'h00);
        check({30'h0, rs}, {30'h0, ppo_pkg::RESP_SLVERR});
        $display("test reset values done");
        // disabled bits accept software levels
        wr(ppo_pkg::OFS_LEVEL_HIGH, 8'hA5);
        wr(ppo_pkg::OFS_LEVEL_LOW, 8'h3C);
        lev = 16'hA53C;
        rchk(ppo_pkg::OFS_LEVEL_HIGH, 8'hA5);
        check({30'h0, rs}, {30'h0, ppo_pkg::RESP_OKAY});
        check({16'h0000, pulse_out}, {16'h0000, lev});
        check({16'h0000, pins}, {16'h0000, lev & dir});
        $display("test initial levels done");
        // enables read back; enabled level bits ignore writes
        wr(ppo_pkg::OFS_EN_HIGH, 8'hF0);
        wr(ppo_pkg::OFS_EN_LOW, 8'h0F);
        en = 16'hF00F;
        rchk(ppo_pkg::OFS_EN_HIGH, 8'hF0);
        rchk(ppo_pkg::OFS_EN_LOW, 8'h0F);
        wr(ppo_pkg::OFS_LEVEL_HIGH, 8'h00);
        wr(ppo_pkg::OFS_LEVEL_LOW, 8'hFF);
        check({30'h0, rs}, {30'h0, ppo_pkg::RESP_OKAY});
        lev = 16'hA0FC;
        rchk(ppo_pkg::OFS_LEVEL_HIGH, 8'hA0);
        rchk(ppo_pkg::OFS_LEVEL_LOW, 8'hFC);
        $display("test write protection done");
        // every select code with shared triggers; a held match transfers once
        for (k = 0; k < 4; k++) begin
            wr(ppo_pkg::OFS_TRIG_SEL, 8'(8'h55 * k));
            nx = 16'(16'h5AC3 ^ (16'h1111 * (k + 1)));
            wr(ppo_pkg::OFS_NEXT_HIGH, nx[15:8]);
            wr(ppo_pkg::OFS_NEXT_LOW, nx[7:0]);
            rchk(ppo_pkg::OFS_NEXT_HIGH, nx[15:8]);
            rchk(ppo_pkg::OFS_NEXT_LOW, nx[7:0]);
            fire_ch((k + 1) % 4);
            check({16'h0000, pulse_out}, {16'h0000, lev});
            hold <= 4'(4'h1 << k);
            cyc(3);
            lev = xfer(16'hFFFF);
            check({16'h0000, pulse_out}, {16'h0000, lev});
            wr(ppo_pkg::OFS_NEXT_HIGH, ~nx[15:8]);
            cyc(2);
            check({16'h0000, pulse_out}, {16'h0000, lev});
            hold <= 4'h0;
            cyc(2);
        end
        $display("test trigger transfer done");
        // split triggers: group 3 on channel 0 down to group 0 on channel 3
        wr(ppo_pkg::OFS_TRIG_SEL, 8'h1B);
        wr(ppo_pkg::OFS_EN_HIGH, 8'hFF);
        wr(ppo_pkg::OFS_EN_LOW, 8'hFF);
        en = 16'hFFFF;
        // a write with byte strobe 0 is answered but leaves the register alone
        wstrb <= 4'h0;
        wr(ppo_pkg::OFS_EN_LOW, 8'h00);
        wstrb <= 4'hF;
        check({30'h0, rs}, {30'h0, ppo_pkg::RESP_OKAY});
        rchk(ppo_pkg::OFS_EN_LOW, 8'hFF);
        wr(ppo_pkg::OFS_NEXT_HIGH, 8'h60);
        rchk(ppo_pkg::OFS_NEXT_HIGH, 8'h6F);
        wr(ppo_pkg::OFS_NEXT_HIGH_ALT, 8'h09);
        rchk(ppo_pkg::OFS_NEXT_HIGH_ALT, 8'hF9);
        wr(ppo_pkg::OFS_NEXT_LOW, 8'h30);
        rchk(ppo_pkg::OFS_NEXT_LOW, 8'h3F);
        wr(ppo_pkg::OFS_NEXT_LOW_ALT, 8'h0C);
        rchk(ppo_pkg::OFS_NEXT_LOW_ALT, 8'hFC);
        nx = 16'h693C;
        for (k = 0; k < 4; k++) begin
            fire_ch(k);
            lev = xfer(16'(16'hF000 >> (4 * k)));
            check({16'h0000, pulse_out}, {16'h0000, lev});
        end
        wr(6'h3C, 8'hFF);
        check({30'h0, rs}, {30'h0, ppo_pkg::RESP_SLVERR});
        check({16'h0000, pins}, {16'h0000, lev & dir});
        $display("test split triggers done");
        report_and_stop();
    end
endmodule
